// file: hw/dwt_ctrl.sv
`timescale 1ns/1ps
module dwt_ctrl
  import dwt_pkg::*;
#(
  parameter int N_IN  = NUM_AUX_IN,
  parameter int N_OUT = NUM_AUX_OUT,
  parameter int PW    = PACER_W
) (
  input  wire logic                  clk,                 // 100 MHz system clock
  input  wire logic                  nrst,                // sync reset, active low
  input  wire logic [N_IN-1:0]       aux_input_pin,       // auxiliary input pins, async
  input  wire logic                  sync_bus_trigger_in, // sync bus start trigger, async
  input  wire logic                  sync_bus_update_in,  // sync bus update strobe, async
  input  wire logic                  arm,                 // pulse: arm from idle
  input  wire logic                  disarm,              // pulse: stop and return to idle
  input  wire logic [SEL_W-1:0]      trig_src_sel,        // 0 bus, 1..N aux pin
  input  wire logic                  trig_falling,        // 1 falling edge triggers
  input  wire logic                  upd_ext_mode,        // 1 external strobe, 0 pacer
  input  wire logic [SEL_W-1:0]      upd_src_sel,         // 0 bus, 1..N aux pin
  input  wire logic                  upd_active_low,      // 1 falling edge is the strobe
  input  wire logic                  tb_ext_sel,          // 1 external pacer time base
  input  wire logic [SEL_W-1:0]      tb_src_sel,          // 1..N aux pin, 0 none
  input  wire logic                  tb_falling,          // 1 falling edge counts
  input  wire logic [PW-1:0]         pacer_div,           // pacer period minus one, in ticks
  input  wire logic                  upd_mon_active_low,  // update monitor polarity
  input  wire logic [N_OUT-1:0][1:0] aux_out_sel,         // routing per aux output
  output logic      [N_OUT-1:0]      aux_output_pin,      // auxiliary output pins
  output logic                       dac_update,          // one-cycle DAC load pulse
  output logic                       wave_start,          // one-cycle start pulse
  output logic                       armed,               // waiting for trigger
  output logic                       running              // waveform in progress
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dwt_state_t             state;
    logic                   trig_prev;
    logic                   upd_prev;
    logic                   tb_prev;
    logic [PW-1:0]          pacer_cnt;
    logic [START_CNT_W-1:0] start_cnt;
    logic [UPD_CNT_W-1:0]   upd_cnt;
    logic                   dac_update;
    logic                   wave_start;
    logic [N_OUT-1:0]       aux_out;
  } dwt_ctrl_st_t;

  dwt_ctrl_st_t st_r;
  dwt_ctrl_st_t st_nxt;

  logic [N_IN-1:0] aux_s;
  logic            trig_bus_s;
  logic            upd_bus_s;

  // ****************************************
  // helpers
  // ****************************************
  // pick a bus bit or an aux pin by select code
  function automatic logic pick_src(input logic [N_IN-1:0] aux, input logic bus, input logic [SEL_W-1:0] sel);
    logic r;
    r = 1'b0;
    if (sel == SRC_BUS) begin
      r = bus;
    end else begin
      for (int i = 0; i < N_IN; i++) begin
        if (sel == SEL_W'(i + 1)) begin
          r = aux[i];
        end
      end
    end
    return r;
  endfunction

  // edge of the chosen direction between two sampled levels
  function automatic logic edge_hit(input logic cur, input logic prev, input logic falling);
    return falling ? (prev & ~cur) : (cur & ~prev);
  endfunction

  // level of one aux output for its routing code; spare codes park the pin low
  // so a stray select can never fake a monitor pulse
  function automatic logic route_lvl(input logic [1:0] code, input logic start_on, input logic upd_on,
                                     input logic upd_low);
    logic r;
    r = 1'b0;
    unique case (code)
      AOUT_START: begin
        r = start_on;
      end
      AOUT_UPD: begin
        r = upd_on ^ upd_low;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  dwt_sync #(
    .W (N_IN + 2)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({sync_bus_update_in, sync_bus_trigger_in, aux_input_pin}),
    .sync_out ({upd_bus_s, trig_bus_s, aux_s})
  );

  // ****************************************
  // sequencer, pacer and monitors
  // ****************************************
  logic trig_lvl;
  logic upd_lvl;
  logic tb_lvl;
  logic trig_evt;
  logic upd_evt;
  logic tb_tick;
  logic pace_evt;
  logic do_update;

  // levels are compared with last cycle's level, whichever select picked it, so changing a
  // select while running can fake one edge; change selects only while idle
  always_comb begin
    st_nxt    = st_r;
    trig_lvl  = pick_src(aux_s, trig_bus_s, trig_src_sel);
    upd_lvl   = pick_src(aux_s, upd_bus_s, upd_src_sel);
    tb_lvl    = pick_src(aux_s, 1'b0, tb_src_sel);
    trig_evt  = edge_hit(trig_lvl, st_r.trig_prev, trig_falling);
    upd_evt   = edge_hit(upd_lvl, st_r.upd_prev, upd_active_low);
    // no watchdog on the time base: a stalled clock just stalls the pacer
    tb_tick   = tb_ext_sel ? edge_hit(tb_lvl, st_r.tb_prev, tb_falling) : 1'b1;
    pace_evt  = 1'b0;
    do_update = 1'b0;

    st_nxt.trig_prev  = trig_lvl;
    st_nxt.upd_prev   = upd_lvl;
    st_nxt.tb_prev    = tb_lvl;
    st_nxt.wave_start = 1'b0;
    st_nxt.dac_update = 1'b0;

    // pacer counts ticks down and fires on the tick that finds it at zero
    if (st_r.state == ST_RUN && tb_tick) begin
      if (st_r.pacer_cnt == '0) begin
        st_nxt.pacer_cnt = pacer_div;
        pace_evt         = 1'b1;
      end else begin
        st_nxt.pacer_cnt = st_r.pacer_cnt - PW'(1);
      end
    end

    unique case (st_r.state)
      ST_IDLE: begin
        if (arm && !disarm) begin
          st_nxt.state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // updates are dropped here so nothing leaves before the trigger
        if (disarm) begin
          st_nxt.state = ST_IDLE;
        end else if (trig_evt) begin
          st_nxt.state      = ST_RUN;
          st_nxt.wave_start = 1'b1;
          st_nxt.pacer_cnt  = pacer_div;
          st_nxt.start_cnt  = START_CNT_W'(START_PULSE_CYC);
        end
      end
      ST_RUN: begin
        // strobe spacing is the source's duty; strobes closer than that still update
        if (disarm) begin
          st_nxt.state = ST_IDLE;
        end else begin
          do_update = upd_ext_mode ? upd_evt : pace_evt;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase

    // one strobe edge, one load pulse; monitor retriggers on each update
    if (do_update) begin
      st_nxt.dac_update = 1'b1;
      st_nxt.upd_cnt    = UPD_CNT_W'(UPD_PULSE_CYC);
    end else if (st_r.upd_cnt != '0) begin
      st_nxt.upd_cnt = st_r.upd_cnt - UPD_CNT_W'(1);
    end

    if (st_nxt.wave_start == 1'b0 && st_r.start_cnt != '0) begin
      st_nxt.start_cnt = st_r.start_cnt - START_CNT_W'(1);
    end

    // aux output routing, taken from next-state counters so widths are exact
    for (int j = 0; j < N_OUT; j++) begin
      st_nxt.aux_out[j] = route_lvl(aux_out_sel[j], st_nxt.start_cnt != '0, st_nxt.upd_cnt != '0,
                                    upd_mon_active_low);
    end
  end

  // synchronous reset lands on idle with every pulse and counter cleared; monitors
  // routed active low read low until the first edge after release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r       <= '0;
      st_r.state <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign aux_output_pin = st_r.aux_out;
  assign dac_update     = st_r.dac_update;
  assign wave_start     = st_r.wave_start;
  // armed and running decode the state register, so they never glitch on inputs
  assign armed          = (st_r.state == ST_ARMED);
  assign running        = (st_r.state == ST_RUN);

endmodule

// file: hw/dwt_pkg.sv
package dwt_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_AUX_IN  = 6;
  localparam int NUM_AUX_OUT = 6;
  localparam int SEL_W       = 3;
  localparam int PACER_W     = 16;

  // ****************************************
  // source select codes
  // ****************************************
  localparam logic [SEL_W-1:0] SRC_BUS = 3'h0;  // codes 1..6 pick aux pin 0..5

  // aux output routing codes
  localparam logic [1:0] AOUT_LOW   = 2'h0;
  localparam logic [1:0] AOUT_START = 2'h1;
  localparam logic [1:0] AOUT_UPD   = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int START_PULSE_NS  = 50;
  localparam int UPD_PULSE_NS    = 225;
  localparam int START_PULSE_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UPD_PULSE_CYC   = (UPD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_CNT_W     = $clog2(START_PULSE_CYC + 1);
  localparam int UPD_CNT_W       = $clog2(UPD_PULSE_CYC + 1);

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN   = 3'b100
  } dwt_state_t;

endpackage

// file: hw/dwt_sync.sv
`timescale 1ns/1ps
module dwt_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,       // system clock
  input  wire logic         nrst,      // sync reset, active low
  input  wire logic [W-1:0] async_in,  // raw pin levels
  output logic      [W-1:0] sync_out   // levels in clk domain
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dwt_sync_st_t;

  dwt_sync_st_t st_r;
  dwt_sync_st_t st_nxt;

  // first stage feeds only the second; nothing else looks at s1
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;

endmodule

// file: sim/dwt_ctrl_props.sv
`timescale 1ns/1ps
module dwt_ctrl_props
  import dwt_pkg::*;
#(
  parameter int N_OUT = NUM_AUX_OUT
) (
  input wire logic                  clk,                // board clock
  input wire logic                  nrst,               // sync reset, active low
  input wire logic                  arm,                // arm request
  input wire logic                  disarm,             // stop request
  input wire logic                  upd_mon_active_low, // monitor polarity
  input wire logic [N_OUT-1:0][1:0] aux_out_sel,        // output routing
  input wire logic [N_OUT-1:0]      aux_output_pin,     // monitor pins
  input wire logic                  dac_update,         // dac load pulse
  input wire logic                  wave_start,         // start pulse
  input wire logic                  armed,              // waiting for trigger
  input wire logic                  running             // waveform running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [4:0] age_r;  // cycles since last update, saturates so it never wraps into a span
  logic       mon_act;
  // age of the last update; idle value after reset
  always_ff @(posedge clk) begin
    if (!nrst) age_r <= 5'h1f;
    else if (dac_update) age_r <= 5'h01;
    else if (age_r != 5'h1f) age_r <= age_r + 5'h01;
  end
  assign mon_act = dac_update || (age_r < UPD_PULSE_CYC);
  upd_in_run_a: assert property (dac_update |-> $past(running))
    else $error("update outside a run");
  start_armed_a: assert property (wave_start |-> $past(armed) && running && !armed)
    else $error("start without arming");
  start_single_a: assert property (wave_start |=> !wave_start)
    else $error("start pulse too long");
  run_has_start_a: assert property ($rose(running) |-> wave_start)
    else $error("run began without start");
  arm_answer_a: assert property (arm && !disarm && !armed && !running |=> armed)
    else $error("arm not taken");
  disarm_idle_a: assert property (disarm |=> !armed && !running)
    else $error("disarm not taken");
  start_mon_a: assert property (wave_start && aux_out_sel[0] == AOUT_START |-> aux_output_pin[0] [*5] ##1 !aux_output_pin[0])
    else $error("start monitor width");
  upd_mon_a: assert property ($stable(aux_out_sel[1]) && $stable(upd_mon_active_low)
    && aux_out_sel[1] == AOUT_UPD |-> aux_output_pin[1] == (mon_act ^ upd_mon_active_low))
    else $error("update monitor width");
  unrouted_low_a: assert property ($stable(aux_out_sel[2]) && aux_out_sel[2] == AOUT_LOW |-> !aux_output_pin[2])
    else $error("unrouted output driven");
  cover property (wave_start);
  cover property (dac_update && running);
  cover property (disarm && running);
endmodule
bind dwt_ctrl dwt_ctrl_props #(.N_OUT(N_OUT)) u_props (.clk(clk), .nrst(nrst), .arm(arm), .disarm(disarm),
  .upd_mon_active_low(upd_mon_active_low), .aux_out_sel(aux_out_sel), .aux_output_pin(aux_output_pin),
  .dac_update(dac_update), .wave_start(wave_start), .armed(armed), .running(running));

// file: sim/dwt_src_model.sv
`timescale 1ns/1ps
module dwt_src_model #(
  parameter int GAP = 3
) (
  input  wire logic       clk,  // board clock
  output logic      [7:0] lv    // aux pins 5..0, bus trigger 6, bus update 7
);
  // lines start low and are always driven, so no floating level exists
  initial lv = 8'h00;
  // quiet cycles before each change keep every phase above 23 ns
  task flip(input int ln);
    repeat (GAP) @(posedge clk);
    lv[ln] <= ~lv[ln];
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dwt_pkg::*;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic               arm = 1'b0;
  logic               disarm = 1'b0;
  logic               trig_falling = 1'b0;
  logic               upd_ext_mode = 1'b1;
  logic               upd_active_low = 1'b0;
  logic               tb_ext_sel = 1'b0;
  logic               tb_falling = 1'b0;
  logic               upd_mon_active_low = 1'b0;
  logic [SEL_W-1:0]   trig_src_sel = 3'h0;
  logic [SEL_W-1:0]   upd_src_sel = 3'h0;
  logic [SEL_W-1:0]   tb_src_sel = 3'h0;
  logic [PACER_W-1:0] pacer_div = 16'h0002;
  logic [5:0][1:0]    aux_out_sel = {8'h00, AOUT_UPD, AOUT_START};
  wire  [7:0]         lv;
  wire  [5:0]         aux_o;
  wire                dac_update, wave_start, armed, running;
  int                 fail_count = 0, n_checks = 0, seed = 64, ups = 0, k, i, c, n, fe;
  dwt_src_model #(.GAP(3)) u_src (.clk(clk), .lv(lv));
  dwt_ctrl u_dut (.clk(clk), .nrst(nrst), .aux_input_pin(lv[5:0]), .sync_bus_trigger_in(lv[6]),
    .sync_bus_update_in(lv[7]), .arm(arm), .disarm(disarm), .trig_src_sel(trig_src_sel),
    .trig_falling(trig_falling), .upd_ext_mode(upd_ext_mode), .upd_src_sel(upd_src_sel),
    .upd_active_low(upd_active_low), .tb_ext_sel(tb_ext_sel), .tb_src_sel(tb_src_sel), .tb_falling(tb_falling),
    .pacer_div(pacer_div), .upd_mon_active_low(upd_mon_active_low), .aux_out_sel(aux_out_sel),
    .aux_output_pin(aux_o), .dac_update(dac_update), .wave_start(wave_start), .armed(armed), .running(running));
  // clock and update counter
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (dac_update === 1'b1) ups <= ups + 1;
  // a hang is cut short well past the expected run length
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  function automatic int line_of(input int code, input int bus);
    return (code == 0) ? bus : code - 1;
  endfunction
  task chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      fail_count++;
      $display("Error %0t %s", $time, msg);
    end
  endtask
  task end_of_test();
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cyc(input int m);
    repeat (m) @(posedge clk);
  endtask
  // cycles until the chosen pulse shows, capped at 12
  task lat(input bit u);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while ((u ? dac_update : wave_start) !== 1'b1 && c < 12);
  endtask
  // arm, give the wrong edge, then the chosen one
  task start_run(input int ln);
    if (lv[ln] === trig_falling) u_src.flip(ln);
    cyc(6);
    arm <= 1'b1;
    cyc(1);
    arm <= 1'b0;
    #1 chk(armed === 1'b1, "arm ignored");
    u_src.flip(ln);
    lat(1'b0);
    chk(c == 12 && armed === 1'b1, "wrong edge started");
    u_src.flip(ln);
    lat(1'b0);
    chk(c >= 3 && c <= 4 && running === 1'b1 && aux_o[0] === 1'b1, "start late");
    chk(aux_o[5:2] === 4'h0, "unrouted pins driven");
  endtask
  // spacing shortened far below the 100 us minimum so the monitor retriggers
  task strobes(input int ln, input int m);
    n = ups;
    if (lv[ln] !== upd_active_low) u_src.flip(ln);
    for (i = 0; i < m; i++) begin
      u_src.flip(ln);
      lat(1'b1);
      chk(c >= 3 && c <= 4 && aux_o[1] === 1'b1, "update late");
      u_src.flip(ln);
    end
    cyc(8);
    chk(ups - n == m, "update count");
  endtask
  task stop();
    cyc(1);
    disarm <= 1'b1;
    cyc(1);
    disarm <= 1'b0;
    #1 chk(running === 1'b0 && armed === 1'b0, "disarm ignored");
  endtask
  // every source and both edge senses, then internal and slow external pacing
  initial begin
    cyc(5);
    chk(armed === 1'b0 && running === 1'b0 && aux_o === 6'h00, "reset outputs");
    nrst <= 1'b1;
    cyc(3);
    for (k = 0; k < 7; k++) begin
      trig_src_sel <= 3'(k);
      upd_src_sel <= 3'((k + 3) % 7);
      trig_falling <= k[0];
      upd_active_low <= k[1];
      cyc(2);
      start_run(line_of(k, 6));
      strobes(line_of((k + 3) % 7, 7), 1 + ($random(seed) & 3));
      stop();
      n = ups;
      u_src.flip(line_of((k + 3) % 7, 7));
      u_src.flip(line_of((k + 3) % 7, 7));
      cyc(8);
      chk(ups == n, "idle strobe");
      chk(dac_update === 1'b0 && running === 1'b0, "idle update");
    end
    upd_ext_mode <= 1'b0;
    trig_src_sel <= 3'h0;
    trig_falling <= 1'b0;
    pacer_div <= 16'(2 + ($random(seed) & 7));
    cyc(2);
    start_run(6);
    lat(1'b1);
    for (i = 0; i < 3; i++) begin
      lat(1'b1);
      chk(c == pacer_div + 1, "pacer period");
    end
    stop();
    tb_ext_sel <= 1'b1;
    tb_src_sel <= 3'h2;
    upd_mon_active_low <= 1'b1;
    pacer_div <= 16'h0002;
    // falling then rising time base edges, the second pass slower still
    for (k = 0; k < 2; k++) begin
      tb_falling <= ~k[0];
      cyc(4);
      start_run(6);
      n = ups;
      fe = 0;
      for (i = 0; i < 12; i++) begin
        fe += (lv[1] === tb_falling);
        u_src.flip(1);
        cyc(20 + 40 * k);
      end
      cyc(8);
      chk(ups - n == fe / 3, "external base count");
      stop();
    end
    end_of_test();
  end
endmodule
